// *** pkg/mcs_pkg.sv ***
// constants and carrier types of the receive-direction 2-d descriptor writer
// assumes a 32-bit memory data bus and a 32-bit inbound stream
package mcs_pkg;

    //////////////////////////////////////////////////////////////////////////
    // descriptor layout
    localparam int          DESC_WORDS      = 8;
    localparam logic [7:0]  OFS_NEXT_LO     = 8'h00;
    localparam logic [7:0]  OFS_NEXT_HI     = 8'h04;
    localparam logic [7:0]  OFS_BUF_LO      = 8'h08;
    localparam logic [7:0]  OFS_BUF_HI      = 8'h0c;
    localparam logic [7:0]  OFS_SIDEBAND    = 8'h10;
    localparam logic [7:0]  OFS_PITCH_COUNT = 8'h14;
    localparam logic [7:0]  OFS_LINE_LEN    = 8'h18;
    localparam logic [7:0]  OFS_STATUS      = 8'h1c;
    localparam int          NEXT_LSB        = 6;
    localparam int          CACHE_LSB       = 24;
    localparam int          USER_LSB        = 28;
    localparam int          PITCH_LSB       = 0;
    localparam int          PITCH_W         = 16;
    localparam int          LCOUNT_LSB      = 19;
    localparam int          LCOUNT_W        = 13;
    localparam int          LLEN_LSB        = 0;
    localparam int          LLEN_W          = 16;
    localparam int          EOP_BIT         = 26;
    localparam int          INT_ERR_BIT     = 28;

    //////////////////////////////////////////////////////////////////////////
    // memory bus encodings
    localparam int          DATA_BYTES      = 4;
    localparam logic [15:0] BEAT_BYTES      = 16'h0004;
    localparam logic [63:0] BEAT_STEP       = 64'h4;
    localparam logic [7:0]  LEN_DESC        = 8'h07;
    localparam logic [7:0]  LEN_SINGLE      = 8'h00;
    localparam logic [2:0]  SIZE_WORD       = 3'h2;
    localparam logic [1:0]  BURST_INCR      = 2'h1;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [3:0]  STRB_ALL        = 4'hf;

    //////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed
    {
        logic [63:0]         next_ptr;
        logic [63:0]         buf_addr;
        logic [3:0]          cache;
        logic [3:0]          user;
        logic [PITCH_W-1:0]  pitch;
        logic [LCOUNT_W-1:0] line_count;
        logic [LLEN_W-1:0]   line_len;
    } mcs_desc_t;

    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_AR,
        ST_RD,
        ST_CHECK,
        ST_TAKE,
        ST_WRITE,
        ST_RESP,
        ST_STS_WR,
        ST_STS_RESP
    } mcs_state_e;

endpackage : mcs_pkg

// *** design/mcs_desc_decode.sv ***
// field decoder for one fetched receive descriptor
// assumes the eight words are held stable by the caller while in use
`timescale 1ns/1ps
module mcs_desc_decode
    import mcs_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // fetched words
    input  wire logic [DESC_WORDS-1:0][31:0] words_in,
    // decoded fields
    output mcs_desc_t                        desc_out
);

    always_comb
    begin
        desc_out            = '0;
        desc_out.next_ptr   = {32'h0, words_in[OFS_NEXT_LO[7:2]][31:NEXT_LSB], 6'h00};
        desc_out.buf_addr   = {32'h0, words_in[OFS_BUF_LO[7:2]]};
        if (ADDR_W > 32)
        begin
            desc_out.next_ptr[63:32] = words_in[OFS_NEXT_HI[7:2]];
            desc_out.buf_addr[63:32] = words_in[OFS_BUF_HI[7:2]];
        end
        desc_out.cache      = words_in[OFS_SIDEBAND[7:2]][CACHE_LSB +: 4];
        desc_out.user       = words_in[OFS_SIDEBAND[7:2]][USER_LSB +: 4];
        desc_out.pitch      = words_in[OFS_PITCH_COUNT[7:2]][PITCH_LSB +: PITCH_W];
        desc_out.line_count = words_in[OFS_PITCH_COUNT[7:2]][LCOUNT_LSB +: LCOUNT_W];
        desc_out.line_len   = words_in[OFS_LINE_LEN[7:2]][LLEN_LSB +: LLEN_W];
    end

endmodule : mcs_desc_decode

// *** design/mcs_stream_to_memory_writer.sv ***
// receive-direction descriptor walker and 2-d strided memory writer
// assumes descriptors in memory reachable over the same 32-bit memory bus,
// lines packed from byte 0 of a fresh stream beat, base and pitch word aligned
`timescale 1ns/1ps
module mcs_stream_to_memory_writer
    import mcs_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    // control
    input  wire logic              start_in,
    input  wire logic [63:0]       first_desc_in,
    input  wire logic              run_in,
    output logic                   busy_out,
    output logic                   desc_done_out,
    output logic                   packet_end_flag_out,
    output logic                   error_out,
    // inbound stream
    input  wire logic              inbound_stream_port_tvalid_in,
    input  wire logic [31:0]       inbound_stream_port_tdata_in,
    input  wire logic              inbound_stream_port_tlast_in,
    output logic                   inbound_stream_port_tready_out,
    // memory read address and data
    output logic                   m_axi_arvalid_out,
    input  wire logic              m_axi_arready_in,
    output logic [ADDR_W-1:0]      m_axi_araddr_out,
    output logic [7:0]             m_axi_arlen_out,
    output logic [2:0]             m_axi_arsize_out,
    output logic [1:0]             m_axi_arburst_out,
    input  wire logic              m_axi_rvalid_in,
    input  wire logic [31:0]       m_axi_rdata_in,
    input  wire logic [1:0]        m_axi_rresp_in,
    input  wire logic              m_axi_rlast_in,
    output logic                   m_axi_rready_out,
    // memory write address, data and response
    output logic                   m_axi_awvalid_out,
    input  wire logic              m_axi_awready_in,
    output logic [ADDR_W-1:0]      m_axi_awaddr_out,
    output logic [7:0]             m_axi_awlen_out,
    output logic [2:0]             m_axi_awsize_out,
    output logic [1:0]             m_axi_awburst_out,
    output logic [3:0]             m_axi_awcache_out,
    output logic [3:0]             m_axi_awuser_out,
    output logic                   m_axi_wvalid_out,
    input  wire logic              m_axi_wready_in,
    output logic [31:0]            m_axi_wdata_out,
    output logic [3:0]             m_axi_wstrb_out,
    output logic                   m_axi_wlast_out,
    input  wire logic              m_axi_bvalid_in,
    input  wire logic [1:0]        m_axi_bresp_in,
    output logic                   m_axi_bready_out
);

    initial
    begin
        if (ADDR_W != 32 && ADDR_W != 64)
            $error("ADDR_W must be 32 or 64");
    end

    typedef struct packed
    {
        mcs_state_e                  st;
        logic [DESC_WORDS-1:0][31:0] words;
        logic [2:0]                  widx;
        logic [63:0]                 desc_ptr;
        logic [63:0]                 line_addr;
        logic [63:0]                 beat_addr;
        logic [LCOUNT_W-1:0]         lines_left;
        logic [LLEN_W-1:0]           bytes_left;
        logic                        eop;
        logic                        err;
        logic                        done;
        logic                        tready;
        logic                        arvalid;
        logic                        rready;
        logic                        awvalid;
        logic [63:0]                 awaddr;
        logic [3:0]                  awcache;
        logic [3:0]                  awuser;
        logic                        wvalid;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        bready;
    } mcs_regs_t;

    mcs_regs_t s_reg;
    mcs_regs_t s_next;
    mcs_desc_t desc;
    logic      aw_left;
    logic      w_left;
    logic      final_beat;

    mcs_desc_decode #(.ADDR_W(ADDR_W)) u_decode
    (
        .words_in (s_reg.words),
        .desc_out (desc)
    );

    assign aw_left    = s_reg.awvalid && !m_axi_awready_in;
    assign w_left     = s_reg.wvalid && !m_axi_wready_in;
    assign final_beat = (s_reg.lines_left == 13'h0001) && (s_reg.bytes_left <= BEAT_BYTES);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb
    begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        case (s_reg.st)
            ST_IDLE:
            begin
                if (start_in)
                begin
                    s_next.desc_ptr = first_desc_in;
                    s_next.arvalid  = 1'b1;
                    s_next.st       = ST_AR;
                end
            end
            ST_AR:
            begin
                if (m_axi_arready_in)
                begin
                    s_next.arvalid = 1'b0;
                    s_next.rready  = 1'b1;
                    s_next.widx    = 3'h0;
                    s_next.st      = ST_RD;
                end
            end
            ST_RD:
            begin
                if (m_axi_rvalid_in)
                begin
                    s_next.words[s_reg.widx] = m_axi_rdata_in;
                    s_next.widx              = s_reg.widx + 3'h1;
                    if (m_axi_rresp_in != RESP_OKAY)
                        s_next.err = 1'b1;
                    if (m_axi_rlast_in)
                    begin
                        s_next.rready = 1'b0;
                        s_next.st     = ST_CHECK;
                    end
                end
            end
            ST_CHECK:
            begin
                // fresh descriptor: reset geometry and the packet end flag, keep the error flag
                s_next.line_addr  = desc.buf_addr;
                s_next.beat_addr  = desc.buf_addr;
                s_next.lines_left = desc.line_count;
                s_next.bytes_left = desc.line_len;
                s_next.awcache    = desc.cache;
                s_next.awuser     = desc.user;
                s_next.eop        = 1'b0;
                s_next.err        = s_reg.err;
                // a zero count would wrap the line counter, a zero length would write beats with no strobes
                if (desc.line_count == '0 || desc.line_len == '0)
                begin
                    s_next.err     = 1'b1;
                    s_next.awaddr  = s_reg.desc_ptr + {56'h0, OFS_STATUS};
                    s_next.wdata   = 32'h0 | (32'h1 << INT_ERR_BIT);
                    s_next.wstrb   = STRB_ALL;
                    s_next.awvalid = 1'b1;
                    s_next.wvalid  = 1'b1;
                    s_next.st      = ST_STS_WR;
                end
                else
                begin
                    s_next.tready = 1'b1;
                    s_next.st     = ST_TAKE;
                end
            end
            ST_TAKE:
            begin
                if (inbound_stream_port_tvalid_in)
                begin
                    s_next.tready  = 1'b0;
                    s_next.awaddr  = s_reg.beat_addr;
                    s_next.wdata   = inbound_stream_port_tdata_in;
                    s_next.wstrb   = (s_reg.bytes_left >= BEAT_BYTES) ? STRB_ALL
                                   : 4'((5'h01 << s_reg.bytes_left[2:0]) - 5'h01);
                    s_next.awvalid = 1'b1;
                    s_next.wvalid  = 1'b1;
                    s_next.eop     = inbound_stream_port_tlast_in;
                    // tlast anywhere but the final beat breaks the packet shape
                    if (inbound_stream_port_tlast_in != final_beat)
                        s_next.err = 1'b1;
                    s_next.st      = ST_WRITE;
                end
            end
            ST_WRITE, ST_STS_WR:
            begin
                s_next.awvalid = aw_left;
                s_next.wvalid  = w_left;
                if (!aw_left && !w_left)
                begin
                    s_next.bready = 1'b1;
                    s_next.st     = (s_reg.st == ST_WRITE) ? ST_RESP : ST_STS_RESP;
                end
            end
            ST_RESP:
            begin
                if (m_axi_bvalid_in)
                begin
                    s_next.bready = 1'b0;
                    if (m_axi_bresp_in != RESP_OKAY)
                        s_next.err = 1'b1;
                    if (final_beat)
                    begin
                        s_next.awaddr  = s_reg.desc_ptr + {56'h0, OFS_STATUS};
                        s_next.wdata   = ({31'h0, s_reg.eop} << EOP_BIT)
                                       | ({31'h0, s_next.err} << INT_ERR_BIT);
                        s_next.wstrb   = STRB_ALL;
                        s_next.awvalid = 1'b1;
                        s_next.wvalid  = 1'b1;
                        s_next.st      = ST_STS_WR;
                    end
                    else if (s_reg.bytes_left <= BEAT_BYTES)
                    begin
                        s_next.line_addr  = s_reg.line_addr + {48'h0, desc.pitch};
                        s_next.beat_addr  = s_reg.line_addr + {48'h0, desc.pitch};
                        s_next.lines_left = s_reg.lines_left - 13'h0001;
                        s_next.bytes_left = desc.line_len;
                        s_next.tready     = 1'b1;
                        s_next.st         = ST_TAKE;
                    end
                    else
                    begin
                        s_next.beat_addr  = s_reg.beat_addr + BEAT_STEP;
                        s_next.bytes_left = s_reg.bytes_left - BEAT_BYTES;
                        s_next.tready     = 1'b1;
                        s_next.st         = ST_TAKE;
                    end
                end
            end
            ST_STS_RESP:
            begin
                if (m_axi_bvalid_in)
                begin
                    s_next.bready   = 1'b0;
                    s_next.done     = 1'b1;
                    if (m_axi_bresp_in != RESP_OKAY)
                        s_next.err = 1'b1;
                    s_next.desc_ptr = desc.next_ptr;
                    s_next.arvalid  = run_in;
                    s_next.st       = run_in ? ST_AR : ST_IDLE;
                end
            end
            default:
            begin
                s_next = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register or constants
    assign busy_out                       = (s_reg.st != ST_IDLE);
    assign desc_done_out                  = s_reg.done;
    assign packet_end_flag_out            = s_reg.eop;
    assign error_out                      = s_reg.err;
    assign inbound_stream_port_tready_out = s_reg.tready;
    assign m_axi_arvalid_out              = s_reg.arvalid;
    assign m_axi_araddr_out               = s_reg.desc_ptr[ADDR_W-1:0];
    assign m_axi_arlen_out                = LEN_DESC;
    assign m_axi_arsize_out               = SIZE_WORD;
    assign m_axi_arburst_out              = BURST_INCR;
    assign m_axi_rready_out               = s_reg.rready;
    assign m_axi_awvalid_out              = s_reg.awvalid;
    assign m_axi_awaddr_out               = s_reg.awaddr[ADDR_W-1:0];
    assign m_axi_awlen_out                = LEN_SINGLE;
    assign m_axi_awsize_out               = SIZE_WORD;
    assign m_axi_awburst_out              = BURST_INCR;
    assign m_axi_awcache_out              = s_reg.awcache;
    assign m_axi_awuser_out               = s_reg.awuser;
    assign m_axi_wvalid_out               = s_reg.wvalid;
    assign m_axi_wdata_out                = s_reg.wdata;
    assign m_axi_wstrb_out                = s_reg.wstrb;
    assign m_axi_wlast_out                = s_reg.wvalid;
    assign m_axi_bready_out               = s_reg.bready;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    chk_desc_aligned: assert property (s_reg.arvalid |-> s_reg.desc_ptr[5:0] == 6'h00)
        else $error("descriptor fetch not 64-byte aligned");
    chk_chain_follow: assert property (s_reg.done && run_in |=> m_axi_araddr_out == $past(desc.next_ptr[ADDR_W-1:0]))
        else $error("next fetch does not follow the chain pointer");
    chk_first_beat: assert property ($rose(s_reg.tready) && s_reg.st == ST_TAKE && $past(s_reg.st) == ST_CHECK
                                     |-> s_reg.beat_addr == desc.buf_addr)
        else $error("first write not at buffer base");
    chk_cache_side: assert property (s_reg.awvalid |-> s_reg.awcache == desc.cache)
        else $error("awcache differs from descriptor");
    chk_user_side: assert property (s_reg.awvalid |-> m_axi_awuser_out == desc.user)
        else $error("awuser differs from descriptor");
    chk_line_step: assert property (s_reg.st == ST_RESP && m_axi_bvalid_in && !final_beat
                                    && s_reg.bytes_left <= BEAT_BYTES
                                    |=> s_reg.beat_addr == $past(s_reg.line_addr) + {48'h0, desc.pitch})
        else $error("next line not one pitch after previous");
    chk_beat_step: assert property (s_reg.st == ST_RESP && m_axi_bvalid_in && s_reg.bytes_left > BEAT_BYTES
                                    |=> s_reg.beat_addr == $past(s_reg.beat_addr) + BEAT_STEP)
        else $error("beat address not contiguous inside line");
    chk_line_count: assert property ($rose(s_reg.tready) && $past(s_reg.st) == ST_CHECK
                                     |-> s_reg.lines_left == desc.line_count)
        else $error("line count not loaded from descriptor");
    chk_line_len: assert property ($rose(s_reg.tready) && $past(s_reg.st) == ST_CHECK
                                   |-> s_reg.bytes_left == desc.line_len)
        else $error("line length not loaded from descriptor");
    chk_eop_status: assert property (s_reg.st == ST_STS_WR && s_reg.wvalid
                                     |-> s_reg.wdata[EOP_BIT] == s_reg.eop
                                         && s_reg.awaddr == s_reg.desc_ptr + {56'h0, OFS_STATUS})
        else $error("status write does not carry packet end flag");
    chk_tlast_shape: assert property (s_reg.tready && inbound_stream_port_tvalid_in
                                      && inbound_stream_port_tlast_in != final_beat |=> s_reg.err)
        else $error("misplaced tlast not flagged");

endmodule : mcs_stream_to_memory_writer

// *** verification/mcs_mem_model.sv ***
// memory partner: descriptor store, burst reads, single-beat writes
// assumes 32-bit addresses below 4 kbyte; the bench preloads mem directly
`timescale 1ns/1ps
module mcs_mem_model
    import mcs_pkg::*;
(
    // clock, reset and slow-answer mode
    input  wire logic        clk_in, rst_in, slow_in,
    // read channels
    input  wire logic        arv_in, rr_in,
    input  wire logic [31:0] ara_in,
    input  wire logic [7:0]  arl_in,
    output logic             arr_out, rv_out, rl_out,
    output logic [31:0]      rd_out,
    // write channels
    input  wire logic        awv_in, wv_in, br_in,
    input  wire logic [31:0] awa_in, wd_in,
    input  wire logic [3:0]  ws_in,
    output logic             awr_out, wr_out, bv_out
);
    logic [31:0] mem [0:1023];
    logic [9:0]  ridx;
    logic [7:0]  rleft;
    logic        tick;
    ////////////////////////////////////////////////////////////////////////////
    // slow mode withholds every ready on alternate cycles
    assign arr_out = ~rv_out & ~(slow_in & tick);
    assign awr_out = awv_in & wv_in & ~bv_out & ~(slow_in & tick);
    assign wr_out  = awr_out;
    // idle read bus shows inverted data so a stale word never looks fresh
    assign rd_out  = rv_out ? mem[ridx] : ~mem[ridx];
    assign rl_out  = rleft == 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            tick   <= 1'b0;
            rv_out <= 1'b0;
            bv_out <= 1'b0;
        end
        else
        begin
            tick <= ~tick;
            if (arv_in && arr_out)
            begin
                rv_out <= 1'b1;
                ridx   <= ara_in[11:2];
                rleft  <= arl_in;
            end
            if (rv_out && rr_in)
            begin
                ridx   <= ridx + 10'h1;
                rleft  <= rleft - 8'h1;
                rv_out <= rleft != 8'h00;
            end
            if (awr_out)
            begin
                for (int i = 0; i < 4; i++)
                    if (ws_in[i])
                        mem[awa_in[11:2]][8*i +: 8] <= wd_in[8*i +: 8];
                bv_out <= 1'b1;
            end
            else if (bv_out && br_in)
                bv_out <= 1'b0;
        end
    end
endmodule : mcs_mem_model

// *** verification/mcs_stream_to_memory_writer_bench.sv ***
// bench: single-descriptor rows, a two-descriptor chain, an early packet end
// assumes the writer at 32-bit addresses facing the memory partner model
`timescale 1ns/1ps
module mcs_stream_to_memory_writer_bench;
    import mcs_pkg::*;
    typedef struct packed {logic [31:0] base; logic [15:0] pitch; logic [12:0] cnt; logic [15:0] len;
        logic [3:0] cache; logic [3:0] user;} mcs_row_t;
    localparam mcs_row_t ROWS [4] = '{'{32'h400, 16'h10, 13'h3, 16'h8, 4'h3, 4'h5},
        '{32'h800, 16'hc, 13'h2, 16'h6, 4'hf, 4'ha}, '{32'ha00, 16'h4, 13'h1, 16'h1, 4'h0, 4'h0},
        '{32'hc00, 16'h14, 13'h4, 16'h4, 4'h3, 4'h3}};
    logic        core_clk_in = 1'b0;
    logic        rst_in, start_in, run_in, slow, busy_out, desc_done_out, packet_end_flag_out, error_out;
    logic [63:0] first_desc_in;
    logic        inbound_stream_port_tvalid_in, inbound_stream_port_tlast_in, inbound_stream_port_tready_out;
    logic        m_axi_arvalid_out, m_axi_arready_in, m_axi_rvalid_in, m_axi_rlast_in, m_axi_rready_out;
    logic        m_axi_awvalid_out, m_axi_awready_in, m_axi_wvalid_out, m_axi_wready_in, m_axi_wlast_out;
    logic        m_axi_bvalid_in, m_axi_bready_out;
    logic [31:0] inbound_stream_port_tdata_in, m_axi_araddr_out, m_axi_rdata_in, m_axi_awaddr_out, m_axi_wdata_out;
    logic [7:0]  m_axi_arlen_out, m_axi_awlen_out;
    logic [2:0]  m_axi_arsize_out, m_axi_awsize_out;
    logic [1:0]  m_axi_arburst_out, m_axi_awburst_out, m_axi_rresp_in, m_axi_bresp_in;
    logic [3:0]  m_axi_awcache_out, m_axi_awuser_out, m_axi_wstrb_out, exp_cache, exp_user;
    int          num_errors = 0, cmp_count = 0, cycles = 0;
    mcs_row_t    r2;
    ////////////////////////////////////////////////////////////////////////////
    always #12.5 core_clk_in = ~core_clk_in;
    assign m_axi_rresp_in = RESP_OKAY;
    assign m_axi_bresp_in = RESP_OKAY;
    mcs_stream_to_memory_writer #(.ADDR_W(32)) i_mcs_stream_to_memory_writer (.*);
    mcs_mem_model i_mcs_mem_model (.clk_in(core_clk_in), .rst_in(rst_in), .slow_in(slow), .arv_in(m_axi_arvalid_out),
        .rr_in(m_axi_rready_out), .ara_in(m_axi_araddr_out), .arl_in(m_axi_arlen_out), .arr_out(m_axi_arready_in),
        .rv_out(m_axi_rvalid_in), .rl_out(m_axi_rlast_in), .rd_out(m_axi_rdata_in), .awv_in(m_axi_awvalid_out),
        .wv_in(m_axi_wvalid_out), .br_in(m_axi_bready_out), .awa_in(m_axi_awaddr_out), .wd_in(m_axi_wdata_out),
        .ws_in(m_axi_wstrb_out), .awr_out(m_axi_awready_in), .wr_out(m_axi_wready_in), .bv_out(m_axi_bvalid_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    function automatic logic [7:0] pb(input int k, input int j);
        return 8'(k * 37 + j + 1);
    endfunction : pb
    function automatic logic [7:0] mb(input logic [31:0] a);
        return i_mcs_mem_model.mem[a[11:2]][8*a[1:0] +: 8];
    endfunction : mb
    task automatic mk_desc(input logic [31:0] a, input mcs_row_t r, input logic [31:0] nxt);
        for (int w = 256; w < 1024; w++)
            i_mcs_mem_model.mem[w] = 32'ha5a5a5a5;
        exp_cache = r.cache;
        exp_user = r.user;
        i_mcs_mem_model.mem[a[11:2]] = nxt;
        i_mcs_mem_model.mem[a[11:2] + 10'h1] = 32'hffffffff;
        i_mcs_mem_model.mem[a[11:2] + 10'h2] = r.base;
        i_mcs_mem_model.mem[a[11:2] + 10'h3] = 32'hffffffff;
        i_mcs_mem_model.mem[a[11:2] + 10'h4] = {r.user, r.cache, 24'hffffff};
        i_mcs_mem_model.mem[a[11:2] + 10'h5] = {r.cnt, 3'h7, r.pitch};
        i_mcs_mem_model.mem[a[11:2] + 10'h6] = {16'hffff, r.len};
        i_mcs_mem_model.mem[a[11:2] + 10'h7] = 32'h0;
    endtask : mk_desc
    task automatic go(input logic [31:0] a);
        @(posedge core_clk_in);
        start_in <= 1'b1;
        first_desc_in <= {32'h0, a};
        @(posedge core_clk_in);
        start_in <= 1'b0;
    endtask : go
    task automatic beat(input logic [31:0] d, input logic l);
        @(posedge core_clk_in);
        inbound_stream_port_tvalid_in <= 1'b1;
        inbound_stream_port_tdata_in <= d;
        inbound_stream_port_tlast_in <= l;
        @(posedge core_clk_in);
        while (inbound_stream_port_tready_out !== 1'b1)
            @(posedge core_clk_in);
        inbound_stream_port_tvalid_in <= 1'b0;
        inbound_stream_port_tdata_in <= ~d;
    endtask : beat
    // each line starts on a fresh beat; early moves the packet end to the first beat
    task automatic finish_desc(input mcs_row_t r, input logic early);
        int nb;
        nb = (int'(r.len) + 3) / 4;
        for (int k = 0; k < int'(r.cnt); k++)
            for (int b = 0; b < nb; b++)
                beat({pb(k, 4*b+3), pb(k, 4*b+2), pb(k, 4*b+1), pb(k, 4*b)},
                    early ? (k == 0 && b == 0) : (k == int'(r.cnt) - 1 && b == nb - 1));
        while (desc_done_out !== 1'b1)
            @(posedge core_clk_in);
        check(32'(packet_end_flag_out), 32'(!early), "end flag out");
        check(32'(error_out), 32'(early), "error out");
    endtask : finish_desc
    task automatic check_desc(input logic [31:0] a, input mcs_row_t r, input logic early);
        logic [31:0] st;
        st = i_mcs_mem_model.mem[a[11:2] + 10'h7];
        check(32'(st[EOP_BIT]), 32'(!early), "status end");
        check(32'(st[INT_ERR_BIT]), 32'(early), "status error");
        for (int k = 0; k < int'(r.cnt); k++)
            for (int j = 0; j < int'(r.pitch); j++)
                check(32'(mb(r.base + 32'(k) * 32'(r.pitch) + 32'(j))),
                    32'(j < int'(r.len) ? pb(k, j) : 8'ha5), "data");
    endtask : check_desc
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (m_axi_awvalid_out === 1'b1 && m_axi_awready_in === 1'b1)
        begin
            check(32'(m_axi_awcache_out), 32'(exp_cache), "awcache");
            check(32'(m_axi_awuser_out), 32'(exp_user), "awuser");
        end
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    initial
    begin
        rst_in <= 1'b1;
        start_in <= 1'b0;
        first_desc_in <= 64'h0;
        run_in <= 1'b0;
        slow <= 1'b0;
        inbound_stream_port_tvalid_in <= 1'b0;
        inbound_stream_port_tdata_in <= 32'h0;
        inbound_stream_port_tlast_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        check(32'(busy_out), 32'h0, "idle after reset");
        for (int i = 0; i < 4; i++)
        begin
            slow <= i[0];
            mk_desc(32'h40 * (i + 1), ROWS[i], 32'h0);
            go(32'h40 * (i + 1));
            finish_desc(ROWS[i], 1'b0);
            check_desc(32'h40 * (i + 1), ROWS[i], 1'b0);
            @(posedge core_clk_in);
            check(32'(busy_out), 32'h0, "idle after row");
            $display("row %0d done", i);
        end
        r2 = ROWS[0];
        r2.base = 32'h600;
        mk_desc(32'h300, ROWS[0], 32'h37f);
        mk_desc(32'h340, r2, 32'h0);
        run_in <= 1'b1;
        go(32'h300);
        go(32'h80);  // start while busy must be ignored
        finish_desc(ROWS[0], 1'b0);
        run_in <= 1'b0;
        finish_desc(r2, 1'b0);
        check_desc(32'h300, ROWS[0], 1'b0);
        check_desc(32'h340, r2, 1'b0);
        $display("chain done");
        mk_desc(32'h40, ROWS[3], 32'h0);
        go(32'h40);
        finish_desc(ROWS[3], 1'b1);
        check_desc(32'h40, ROWS[3], 1'b1);
        $display("early end done");
        wrap_up();
    end
endmodule : mcs_stream_to_memory_writer_bench
